// [hw/dms_defines.svh]
// constants for the decimation mode select block
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_OFF_MODE_A 7'h01
`define DMS_OFF_MODE_B 7'h02
`define DMS_OFF_MODE_SEL 7'h03
`define DMS_BIT_FILTER 3
`define DMS_DEC_MSB 2
`define DMS_MODE_RST 8'h00
`define DMS_SEL_RST 8'h00
`define DMS_NCH 8
// sinc5, clock divided by 32, latencies in master-clock periods
`define DMS_LAT_FIRST_32 1487
`define DMS_LAT_SETTLE_32 6607
`define DMS_LAT_FIRST_64 2511
`define DMS_LAT_SETTLE_64 12751
`define DMS_LAT_FIRST_128 4559
`define DMS_LAT_SETTLE_128 25039
`define DMS_LAT_FIRST_256 8655
`define DMS_LAT_SETTLE_256 49615
`define DMS_LAT_FIRST_512 16847
`define DMS_LAT_SETTLE_512 98767
`define DMS_LAT_FIRST_1024 33231
`define DMS_LAT_SETTLE_1024 197071
`endif

// [hw/dms_lat_timer.sv]
// latency timer for one group: first ready and settled pulses
`timescale 1ns/100ps
`include "dms_defines.svh"
module dms_lat_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic active,
    input wire dms_pkg::dms_dec_t dec,
    output logic first_pulse,
    output logic settled_pulse
);
    logic [17:0] cnt_r;
    logic [17:0] first_lim;
    logic [17:0] settle_lim;
    logic run_r;

    always_comb begin
        case (dec)
            3'h0: begin
                first_lim = 18'(`DMS_LAT_FIRST_32);
                settle_lim = 18'(`DMS_LAT_SETTLE_32);
            end
            3'h1: begin
                first_lim = 18'(`DMS_LAT_FIRST_64);
                settle_lim = 18'(`DMS_LAT_SETTLE_64);
            end
            3'h2: begin
                first_lim = 18'(`DMS_LAT_FIRST_128);
                settle_lim = 18'(`DMS_LAT_SETTLE_128);
            end
            3'h3: begin
                first_lim = 18'(`DMS_LAT_FIRST_256);
                settle_lim = 18'(`DMS_LAT_SETTLE_256);
            end
            3'h4: begin
                first_lim = 18'(`DMS_LAT_FIRST_512);
                settle_lim = 18'(`DMS_LAT_SETTLE_512);
            end
            default: begin
                first_lim = 18'(`DMS_LAT_FIRST_1024);
                settle_lim = 18'(`DMS_LAT_SETTLE_1024);
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 18'h00000;
            run_r <= 1'b0;
            first_pulse <= 1'b0;
            settled_pulse <= 1'b0;
        end else begin
            first_pulse <= 1'b0;
            settled_pulse <= 1'b0;
            if (start) begin
                cnt_r <= 18'h00001;
                run_r <= active;
            end else if (run_r) begin
                cnt_r <= cnt_r + 18'h00001;
                // minus three: two sync stages and the output register
                if (cnt_r == first_lim - 18'h00003) begin
                    first_pulse <= 1'b1;
                end
                if (cnt_r == settle_lim - 18'h00003) begin
                    settled_pulse <= 1'b1;
                    run_r <= 1'b0;
                end
            end
        end
    end
endmodule : dms_lat_timer

// [hw/dms_pkg.sv]
// types for the decimation mode select block
package dms_pkg;
    typedef logic [2:0] dms_dec_t;
    typedef enum logic [2:0] {
        DMS_IDLE = 3'b001,
        DMS_WAIT = 3'b010,
        DMS_DONE = 3'b100
    } dms_state_e;
endpackage : dms_pkg

// [hw/dms_top.sv]
// decimation mode registers, channel mapping and sync latency timing
//
// Functional notes
// RULE1: serial control takes each filter's decimation from mode registers.
// RULE2: two independent modes A and B, each with ratio and filter type.
// RULE3: every channel maps to mode A or B by its select bit.
// RULE4: pin control takes the ratio from two strap pins.
// RULE5: mode bit 3 picks filter: 0 wideband, 1 sinc5.
// RULE6: bits 2:0 decode 32..512; codes 101 to 111 all give 1024.
// RULE7: sinc5 ratio 32, divide-by-32: ready at 1487, settled at 6607.
// RULE8: sinc5 ratio 64: ready at 2511, settled at 12751 periods.
// RULE9: sinc5 ratio 1024: ready at 33231, settled at 197071 periods.
// RULE10: both groups: first ready from faster group; each settles separately.
// RULE11: latency figures hold with data clock at master clock rate.
`timescale 1ns/100ps
`include "dms_defines.svh"
module dms_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PIN_CTRL,
    input wire logic RATIO_STRAP_PIN0,
    input wire logic RATIO_STRAP_PIN1,
    input wire logic SYNC_REQ,
    input wire logic REG_WR,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic [23:0] CH_DEC_CODE,
    output logic [7:0] CH_FILTER_SINC5,
    output logic DATA_READY_OUT,
    output logic SETTLED_A,
    output logic SETTLED_B
);
    logic [7:0] mode_a_r;
    logic [7:0] mode_b_r;
    logic [7:0] mode_sel_r;
    logic [1:0] pin_ctl_s1_r;
    logic [1:0] pin_ctl_s2_r;
    logic [1:0] strap_s1_r;
    logic [1:0] strap_s2_r;
    logic [1:0] sync_s_r;
    logic sync_d_r;
    logic sync_rise;
    logic grp_a_used;
    logic grp_b_used;
    logic first_a;
    logic first_b;
    logic settle_a;
    logic settle_b;
    dms_pkg::dms_dec_t dec_a;
    dms_pkg::dms_dec_t dec_b;
    dms_pkg::dms_state_e state_r;
    dms_pkg::dms_state_e state_nxt;

    // pins are asynchronous, two stages before use
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pin_ctl_s1_r <= 2'h0;
            pin_ctl_s2_r <= 2'h0;
        end else begin
            pin_ctl_s1_r <= {1'b0, PIN_CTRL};
            pin_ctl_s2_r <= pin_ctl_s1_r;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
        end else begin
            strap_s1_r <= {RATIO_STRAP_PIN1, RATIO_STRAP_PIN0};
            strap_s2_r <= strap_s1_r;
        end
    end

    // third stage only feeds the edge detector
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sync_s_r <= 2'h0;
            sync_d_r <= 1'b0;
        end else begin
            sync_s_r <= {sync_s_r[0], SYNC_REQ};
            sync_d_r <= sync_s_r[1];
        end
    end
    assign sync_rise = sync_s_r[1] & ~sync_d_r;

    // RULE2 two mode registers plus select
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mode_a_r <= `DMS_MODE_RST;
            mode_b_r <= `DMS_MODE_RST;
            mode_sel_r <= `DMS_SEL_RST;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `DMS_OFF_MODE_A: mode_a_r <= {4'h0, REG_WDATA[3:0]};
                `DMS_OFF_MODE_B: mode_b_r <= {4'h0, REG_WDATA[3:0]};
                `DMS_OFF_MODE_SEL: mode_sel_r <= REG_WDATA;
                default: mode_sel_r <= mode_sel_r;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else begin
            case (REG_ADDR)
                `DMS_OFF_MODE_A: REG_RDATA <= mode_a_r;
                `DMS_OFF_MODE_B: REG_RDATA <= mode_b_r;
                `DMS_OFF_MODE_SEL: REG_RDATA <= mode_sel_r;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // RULE1 serial: ratio from mode register
    // RULE4 pin control: straps give ratio, filter fixed wideband
    always_comb begin
        if (pin_ctl_s2_r[0]) begin
            dec_a = {1'b0, strap_s2_r};
            dec_b = {1'b0, strap_s2_r};
        end else begin
            dec_a = mode_a_r[`DMS_DEC_MSB:0];
            dec_b = mode_b_r[`DMS_DEC_MSB:0];
        end
    end

    // RULE3 per-channel mapping to A or B
    // RULE5 bit 3 is the sinc5 select
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CH_DEC_CODE <= 24'h000000;
            CH_FILTER_SINC5 <= 8'h00;
        end else begin
            for (int i = 0; i < `DMS_NCH; i++) begin
                if (mode_sel_r[i]) begin
                    CH_DEC_CODE[i*3 +: 3] <= dec_b;
                    CH_FILTER_SINC5[i] <= ~pin_ctl_s2_r[0] &
                        mode_b_r[`DMS_BIT_FILTER];
                end else begin
                    CH_DEC_CODE[i*3 +: 3] <= dec_a;
                    CH_FILTER_SINC5[i] <= ~pin_ctl_s2_r[0] &
                        mode_a_r[`DMS_BIT_FILTER];
                end
            end
        end
    end

    // in serial control a group with no channel mapped stays idle; pin control runs group A only and keeps B idle
    assign grp_b_used = |mode_sel_r & ~pin_ctl_s2_r[0];
    assign grp_a_used = ~(&mode_sel_r) | pin_ctl_s2_r[0];

    // RULE6 codes above 100 decode to 1024 inside the timer
    // RULE7 RULE8 RULE9 table latencies per group
    // RULE11 counts are master clock periods, one per edge
    dms_lat_timer u_tmr_a (
        .clk(CLK_SYS),
        .rst(RST),
        .start(sync_rise),
        .active(grp_a_used),
        .dec(dec_a),
        .first_pulse(first_a),
        .settled_pulse(settle_a)
    );

    dms_lat_timer u_tmr_b (
        .clk(CLK_SYS),
        .rst(RST),
        .start(sync_rise),
        .active(grp_b_used),
        .dec(dec_b),
        .first_pulse(first_b),
        .settled_pulse(settle_b)
    );

    // RULE10 first ready from whichever group is faster
    always_comb begin
        case (state_r)
            dms_pkg::DMS_IDLE:
                state_nxt = sync_rise ? dms_pkg::DMS_WAIT : dms_pkg::DMS_IDLE;
            dms_pkg::DMS_WAIT:
                state_nxt = (first_a | first_b) ? dms_pkg::DMS_DONE :
                    dms_pkg::DMS_WAIT;
            dms_pkg::DMS_DONE:
                state_nxt = sync_rise ? dms_pkg::DMS_WAIT : dms_pkg::DMS_DONE;
            default: state_nxt = dms_pkg::DMS_IDLE;
        endcase
        if (sync_rise) begin
            state_nxt = dms_pkg::DMS_WAIT;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r <= dms_pkg::DMS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // a new sync cancels a ready that would land on its edge
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            DATA_READY_OUT <= 1'b0;
        end else begin
            DATA_READY_OUT <= (state_r == dms_pkg::DMS_WAIT) &
                (first_a | first_b) & ~sync_rise;
        end
    end

    // settled level holds until next sync; stale settle loses to restart
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SETTLED_A <= 1'b0;
            SETTLED_B <= 1'b0;
        end else if (sync_rise) begin
            SETTLED_A <= 1'b0;
            SETTLED_B <= 1'b0;
        end else begin
            SETTLED_A <= SETTLED_A | settle_a;
            SETTLED_B <= SETTLED_B | settle_b;
        end
    end
endmodule : dms_top

// [verif/dms_host_model.sv]
// register host model for the mode registers
`timescale 1ns/100ps
module dms_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic [6:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr = 1'b0;
        addr = 7'h00;
        wdata = 8'h00;
    end
    // strobe held over exactly one rising edge
    task automatic write(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        wdata = ~d;
    endtask : write
    // read data is registered, so sample a cycle later
    task automatic read(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        d = rdata;
    endtask : read
endmodule : dms_host_model

// [verif/dms_top_asserts.sv]
// port assertions for the decimation mode select block
`timescale 1ns/100ps
module dms_top_asserts (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PIN_CTRL,
    input wire logic RATIO_STRAP_PIN0,
    input wire logic RATIO_STRAP_PIN1,
    input wire logic SYNC_REQ,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_RDATA,
    input wire logic [23:0] CH_DEC_CODE,
    input wire logic [7:0] CH_FILTER_SINC5,
    input wire logic DATA_READY_OUT,
    input wire logic SETTLED_A,
    input wire logic SETTLED_B
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [16:0] cnt_r;
    logic sync_q_r;
    // saturating, so a long idle never wraps into a false early count
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cnt_r <= 17'h00000;
            sync_q_r <= 1'b0;
        end else begin
            sync_q_r <= SYNC_REQ;
            if (SYNC_REQ && !sync_q_r)
                cnt_r <= 17'h00000;
            else if (cnt_r != 17'h1FFFF)
                cnt_r <= cnt_r + 17'h00001;
        end
    end
    sequence s_sync;
        !SYNC_REQ ##1 SYNC_REQ;
    endsequence
    sequence s_pin;
        (PIN_CTRL && $stable({RATIO_STRAP_PIN1, RATIO_STRAP_PIN0}))[*5];
    endsequence
    AST_RD_HIGH: assert property (REG_ADDR inside {7'h01, 7'h02} |=>
        REG_RDATA[7:4] == 4'h0) else $error("mode upper bits not zero");
    AST_RD_UNMAP: assert property ((REG_ADDR == 7'h00 ||
        REG_ADDR > 7'h03) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_RDY_ONE: assert property (DATA_READY_OUT |=>
        !DATA_READY_OUT) else $error("ready pulse too long");
    AST_RDY_EARLY: assert property (DATA_READY_OUT |->
        cnt_r >= 17'h005CE) else $error("ready before first latency");
    AST_SET_EARLY: assert property ($rose(SETTLED_A) |->
        cnt_r >= 17'h019CE) else $error("settled before latency");
    AST_SET_CLR: assert property (s_sync |->
        ##[2:5] (!SETTLED_A && !SETTLED_B)) else $error("settled not cleared");
    AST_PIN_DEC: assert property (s_pin |-> CH_DEC_CODE[2:0] ==
        {1'b0, RATIO_STRAP_PIN1, RATIO_STRAP_PIN0}) else $error("pin ratio");
    AST_PIN_MAP: assert property (s_pin |->
        CH_DEC_CODE[23:21] == CH_DEC_CODE[2:0] && CH_FILTER_SINC5 == 8'h00)
        else $error("pin mode mapping");
endmodule : dms_top_asserts
bind dms_top dms_top_asserts chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .PIN_CTRL(PIN_CTRL), .RATIO_STRAP_PIN0(RATIO_STRAP_PIN0),
    .RATIO_STRAP_PIN1(RATIO_STRAP_PIN1), .SYNC_REQ(SYNC_REQ),
    .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .CH_DEC_CODE(CH_DEC_CODE),
    .CH_FILTER_SINC5(CH_FILTER_SINC5), .DATA_READY_OUT(DATA_READY_OUT),
    .SETTLED_A(SETTLED_A), .SETTLED_B(SETTLED_B));

// [verif/tb.sv]
// self-checking testbench for the decimation mode select block
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b0;
    logic s0 = 1'b0;
    logic s1 = 1'b0;
    logic sync = 1'b0;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, rd;
    logic [23:0] dec;
    logic [7:0] sinc5;
    logic data_ready_out, set_a, set_b;
    int fails = 0;
    int num_checks = 0;
    int t_rdy, t_a, t_b, n_rdy;
    always #5 clk = ~clk;
    dms_top uut (.CLK_SYS(clk), .RST(rst), .PIN_CTRL(pin),
        .RATIO_STRAP_PIN0(s0), .RATIO_STRAP_PIN1(s1), .SYNC_REQ(sync),
        .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .CH_DEC_CODE(dec), .CH_FILTER_SINC5(sinc5), .DATA_READY_OUT(data_ready_out),
        .SETTLED_A(set_a), .SETTLED_B(set_b));
    dms_host_model host (.clk(clk), .rdata(rdata), .wr(wr), .addr(addr),
        .wdata(wdata));
    task automatic report_and_stop();
        $display("checks %0d, errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // sample n is taken just after edge n-1 past the request edge
    task automatic lat(input int got, input int exp);
        num_checks++;
        if (got != exp + 1) begin
            fails++;
            $display("Error at %0t: latency %0d for %0d", $time, got, exp);
        end
    endtask : lat
    // early cycles skipped: old settled flags may still stand there
    task automatic run_sync(input int span);
        t_rdy = 0;
        t_a = 0;
        t_b = 0;
        n_rdy = 0;
        repeat (4) @(negedge clk);
        sync = 1'b0;
        repeat (4) @(negedge clk);
        sync = 1'b1;
        for (int n = 1; n <= span; n++) begin
            @(posedge clk);
            #1;
            if (data_ready_out === 1'b1) n_rdy++;
            if (data_ready_out === 1'b1 && t_rdy == 0) t_rdy = n;
            if (n > 6 && set_a === 1'b1 && t_a == 0) t_a = n;
            if (n > 6 && set_b === 1'b1 && t_b == 0) t_b = n;
        end
    endtask : run_sync
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (int a = 0; a < 5; a++) begin
            host.read(7'(a), rd);
            check(24'(rd), 24'h000000);
        end
        for (int c = 0; c < 8; c++) begin
            host.write(7'h01, 8'(8 + c));
            host.read(7'h01, rd);
            check(24'(rd), 24'(8 + c));
            check(24'(dec[2:0] == 3'(c) || (c > 4 && dec[2:0] > 3'h4)), 24'h1);
            check(24'(sinc5), 24'h0000FF);
        end
        host.write(7'h02, 8'hF7);
        host.read(7'h02, rd);
        check(24'(rd), 24'h000007);
        host.write(7'h01, 8'h08);
        host.write(7'h02, 8'h01);
        host.write(7'h03, 8'hAA);
        host.read(7'h03, rd);
        check(24'(rd), 24'h0000AA);
        check(dec, 24'h208208);
        check(24'(sinc5), 24'h000055);
        run_sync(12760);
        lat(t_rdy, 1487);
        lat(t_a, 6607);
        lat(t_b, 12751);
        check(24'(n_rdy), 24'h000001);
        host.write(7'h01, 8'h0D);
        host.write(7'h03, 8'h00);
        run_sync(33240);
        lat(t_rdy, 33231);
        check(24'(t_a), 24'h000000);
        check(24'(t_b), 24'h000000);
        pin = 1'b1;
        s0 = 1'b1;
        repeat (8) @(negedge clk);
        check(dec, 24'h249249);
        check(24'(sinc5), 24'h000000);
        report_and_stop();
    end
endmodule : tb
